/* File: logic/irbt_fifo.sv */
// small flip-flop fifo with valid and ready on both sides
// assumes one clock and an active high asynchronous reset
`timescale 1ns/1ps
module irbt_fifo #(
  parameter int WIDTH = `IRBT_BUS_WIDTH,
  parameter int DEPTH = `IRBT_FIFO_DEPTH
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  output logic      [WIDTH-1:0] outData,
  output logic                  outValid,
  input  wire logic             outReady
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] store [DEPTH];
  logic [AW-1:0]    wrPtr;
  logic [AW-1:0]    rdPtr;
  logic [AW:0]      count;
  logic             doWrite;
  logic             doRead;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  assign inReady  = (count != (AW+1)'(DEPTH));
  assign outValid = (count != '0);
  assign outData  = store[rdPtr];
  assign doWrite  = inValid && inReady;
  assign doRead   = outValid && outReady;

  always_ff @(posedge clk) begin
    if (doWrite) begin
      store[wrPtr] <= inData;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      if (doWrite) begin
        wrPtr <= bump(wrPtr);
      end
      if (doRead) begin
        rdPtr <= bump(rdPtr);
      end
      count <= count + (AW+1)'(doWrite) - (AW+1)'(doRead);
    end
  end
endmodule

/* File: logic/irbt_transceiver.sv */
// inverting registered bus transceiver between buses a and b
// assumes all pins are synchronous to clk; capture clocks are sampled
// inputs whose rising edges are detected, not clock ports
`timescale 1ns/1ps
module irbt_transceiver
  import irbt_pkg::*;
#(
  parameter int WIDTH = `IRBT_BUS_WIDTH,
  parameter int DEPTH = `IRBT_FIFO_DEPTH
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             a_capture_clk,
  input  wire logic             b_capture_clk,
  input  wire logic             a_to_b_source_sel,
  input  wire logic             b_to_a_source_sel,
  input  wire logic             a_to_b_drive_en,
  input  wire logic             b_to_a_drive_en_n,
  input  wire logic [WIDTH-1:0] a_port_in,
  output logic      [WIDTH-1:0] a_port_out,
  output logic      [WIDTH-1:0] a_port_oe,
  input  wire logic [WIDTH-1:0] b_port_in,
  output logic      [WIDTH-1:0] b_port_out,
  output logic      [WIDTH-1:0] b_port_oe,
  output logic      [WIDTH-1:0] aStored,
  output logic      [WIDTH-1:0] bStored,
  output logic      [1:0]       driveMode,
  output logic      [WIDTH-1:0] capData,
  output logic                  capValid,
  input  wire logic             capReady,
  output logic                  capOverrun
);
  logic             aClkLast;
  logic             bClkLast;
  logic             aEdge;
  logic             bEdge;
  logic [WIDTH-1:0] aReg;
  logic [WIDTH-1:0] bReg;
  irbt_drive_t      mode;
  logic [WIDTH-1:0] next_aOut;
  logic [WIDTH-1:0] next_bOut;
  logic             driveA;
  logic             driveB;
  logic [WIDTH-1:0] fifoData;
  logic             fifoValid;
  logic             fifoReady;
  logic             fifoInReady;

  function automatic logic [WIDTH-1:0] invert(input logic [WIDTH-1:0] v);
    invert = ~v;
  endfunction

  assign aEdge  = a_capture_clk && !aClkLast;
  assign bEdge  = b_capture_clk && !bClkLast;
  assign driveB = a_to_b_drive_en;
  assign driveA = !b_to_a_drive_en_n;

  always_comb begin
    unique case ({driveA, driveB})
      2'b00:   mode = IRBT_ISOLATE;
      2'b10:   mode = IRBT_DRIVE_A;
      2'b01:   mode = IRBT_DRIVE_B;
      2'b11:   mode = IRBT_DRIVE_BOTH;
    endcase
  end

  // the bus pins are registered here, so "live" paths lag one clk;
  // this keeps every output on a flip-flop and breaks the a-b loop
  always_comb begin
    next_bOut = a_to_b_source_sel ? invert(aReg) : invert(a_port_in);
    next_aOut = b_to_a_source_sel ? invert(bReg) : invert(b_port_in);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aClkLast <= `IRBT_SYNC_RESET;
      bClkLast <= `IRBT_SYNC_RESET;
    end else begin
      aClkLast <= a_capture_clk;
      bClkLast <= b_capture_clk;
    end
  end

  // pins are read even while driven, so own drive can be captured
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aReg <= `IRBT_REG_RESET;
      bReg <= `IRBT_REG_RESET;
    end else begin
      if (aEdge) begin
        aReg <= a_port_in;
      end
      if (bEdge) begin
        bReg <= b_port_in;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      a_port_out <= `IRBT_REG_RESET;
      b_port_out <= `IRBT_REG_RESET;
      a_port_oe  <= '0;
      b_port_oe  <= '0;
    end else begin
      a_port_out <= next_aOut;
      b_port_out <= next_bOut;
      a_port_oe  <= {WIDTH{driveA}};
      b_port_oe  <= {WIDTH{driveB}};
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aStored   <= `IRBT_REG_RESET;
      bStored   <= `IRBT_REG_RESET;
      driveMode <= 2'(IRBT_ISOLATE);
    end else begin
      aStored   <= aReg;
      bStored   <= bReg;
      driveMode <= 2'(mode);
    end
  end

  // every a-side capture is also queued for a downstream reader;
  // a full queue drops the word and flags it, the register still loads
  irbt_fifo #(
    .WIDTH (WIDTH),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk      (clk),
    .rst      (rst),
    .inData   (a_port_in),
    .inValid  (aEdge),
    .inReady  (fifoInReady),
    .outData  (fifoData),
    .outValid (fifoValid),
    .outReady (fifoReady)
  );

  // output skid: take a word when the holding flop is empty or drained
  assign fifoReady = !capValid || capReady;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      capData  <= `IRBT_REG_RESET;
      capValid <= 1'b0;
    end else if (fifoReady) begin
      capData  <= fifoData;
      capValid <= fifoValid;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      capOverrun <= 1'b0;
    end else begin
      capOverrun <= aEdge && !fifoInReady;
    end
  end
endmodule

/* File: pkg/irbt_pkg.sv */
// types shared by the transceiver design files
// assumes irbt_regs.svh is on the include path
`include "irbt_regs.svh"
package irbt_pkg;
  typedef enum logic [1:0] {
    IRBT_ISOLATE,
    IRBT_DRIVE_A,
    IRBT_DRIVE_B,
    IRBT_DRIVE_BOTH
  } irbt_drive_t;
endpackage

/* File: pkg/irbt_regs.svh */
// named constants for the inverting registered bus transceiver
// assumes inclusion by bare name from the package and design files
`ifndef IRBT_REGS_SVH
`define IRBT_REGS_SVH
`define IRBT_BUS_WIDTH    8
`define IRBT_FIFO_DEPTH   8
`define IRBT_REG_RESET    8'h00
`define IRBT_SYNC_RESET   1'b0
`endif

/* File: testbench/irbt_bus_model.sv */
// far-side bus drivers for both ports
// assumes the far side fills every bit the device leaves undriven
`timescale 1ns/1ps
module irbt_bus_model (
  input  wire logic [7:0] a_port_out,
  input  wire logic [7:0] a_port_oe,
  input  wire logic [7:0] b_port_out,
  input  wire logic [7:0] b_port_oe,
  input  wire logic [7:0] aDrive,
  input  wire logic [7:0] bDrive,
  output logic      [7:0] a_port_in,
  output logic      [7:0] b_port_in
);
  // device wins per bit, so a capture sees its own drive
  assign a_port_in = (a_port_oe & a_port_out) | (~a_port_oe & aDrive);
  assign b_port_in = (b_port_oe & b_port_out) | (~b_port_oe & bDrive);
endmodule

/* File: testbench/irbt_transceiver_checker.sv */
// port assertions for the transceiver
// assumes one clock domain; capture pins held low around reset release
`timescale 1ns/1ps
module irbt_transceiver_checker #(
  parameter int WIDTH = 8
) (
  input wire logic             clk,
  input wire logic             rst,
  input wire logic             a_capture_clk,
  input wire logic             b_capture_clk,
  input wire logic             a_to_b_source_sel,
  input wire logic             b_to_a_source_sel,
  input wire logic             a_to_b_drive_en,
  input wire logic             b_to_a_drive_en_n,
  input wire logic [WIDTH-1:0] a_port_in,
  input wire logic [WIDTH-1:0] b_port_in,
  input wire logic [WIDTH-1:0] a_port_out,
  input wire logic [WIDTH-1:0] b_port_out,
  input wire logic [WIDTH-1:0] a_port_oe,
  input wire logic [WIDTH-1:0] b_port_oe,
  input wire logic [WIDTH-1:0] aStored,
  input wire logic [WIDTH-1:0] bStored
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence riseA; !a_capture_clk ##1 a_capture_clk; endsequence
  sequence riseB; !b_capture_clk ##1 b_capture_clk; endsequence
  a_live_b: assert property (
    a_to_b_drive_en && !a_to_b_source_sel |=> b_port_out == ~$past(a_port_in))
    else $error("b live path wrong");
  a_stored_b: assert property (
    a_to_b_drive_en && a_to_b_source_sel |=> b_port_out == ~aStored) else $error("b stored");
  a_live_a: assert property (
    !b_to_a_drive_en_n && !b_to_a_source_sel |=> a_port_out == ~$past(b_port_in))
    else $error("a live path wrong");
  a_stored_a: assert property (
    !b_to_a_drive_en_n && b_to_a_source_sel |=> a_port_out == ~bStored) else $error("a stored");
  a_cap_a: assert property (
    riseA |=> ##1 aStored == $past(a_port_in, 2)) else $error("a capture wrong");
  a_hold_a: assert property (
    !$rose(a_capture_clk) |=> ##1 $stable(aStored)) else $error("a register moved");
  a_hold_b: assert property (
    !$rose(b_capture_clk) |=> ##1 $stable(bStored)) else $error("b register moved");
  a_cap_b: assert property (
    riseB |=> ##1 bStored == $past(b_port_in, 2)) else $error("b capture wrong");
  a_oe_b: assert property (
    1'b1 |=> b_port_oe == {WIDTH{$past(a_to_b_drive_en)}}) else $error("b enable wrong");
  a_oe_a: assert property (
    1'b1 |=> a_port_oe == {WIDTH{!$past(b_to_a_drive_en_n)}}) else $error("a enable wrong");
endmodule
bind irbt_transceiver irbt_transceiver_checker #(.WIDTH(WIDTH)) chk_u (.*);

/* File: testbench/test_irbt_transceiver.sv */
// self-checking bench: random bus traffic, then a stalled capture stream
// assumes the bus model resolves both ports
`timescale 1ns/1ps
module test_irbt_transceiver;
  logic clk = 0, rst = 1, capReady = 1, pa = 0, pb = 0, capValid, capOverrun;
  logic a_capture_clk = 0, b_capture_clk = 0, a_to_b_source_sel = 0, b_to_a_source_sel = 0;
  logic a_to_b_drive_en = 0, b_to_a_drive_en_n = 1, sa, sb, ea, en, ca, cb;
  logic [7:0] aDrive = 0, bDrive = 0, a_port_in, b_port_in, a_port_out, a_port_oe, capData;
  logic [7:0] b_port_out, b_port_oe, aStored, bStored, aReg = 0, bReg = 0, expA = 0, expB = 0;
  logic [7:0] expAo, expBo, q[$];
  logic [1:0] expMode = 0;
  logic expOeA = 0, expOeB = 0;
  logic [1:0] driveMode;
  logic [31:0] r;
  int errors = 0, checks_done = 0, seed = 32'he7d1fa92, pops = 0, drops = 0, i;
  irbt_transceiver dut_u (.*);
  irbt_bus_model bus_u (.*);
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    if (errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial forever #12.5 clk = ~clk;
  initial begin
    #(25 * 3000);
    errors++;
    close_out();
  end
  always @(posedge clk) if (!rst) begin
    pa <= a_capture_clk;
    pb <= b_capture_clk;
    expA <= aReg;
    expB <= bReg;
    expOeA <= !b_to_a_drive_en_n;
    expOeB <= a_to_b_drive_en;
    expMode <= {a_to_b_drive_en, !b_to_a_drive_en_n};
    expBo <= a_to_b_source_sel ? ~aReg : ~a_port_in;
    expAo <= b_to_a_source_sel ? ~bReg : ~b_port_in;
    if (a_capture_clk && !pa) begin
      aReg <= a_port_in;
      q.push_back(a_port_in);
    end
    if (b_capture_clk && !pb) bReg <= b_port_in;
    if (capValid === 1'b1 && capReady) begin
      check(capData, q[0], "capData");
      q.pop_front();
      pops++;
    end
    drops += int'(capOverrun === 1'b1);
  end
  always @(negedge clk) if (!rst) begin
    check(aStored, expA, "aStored");
    check(bStored, expB, "bStored");
    check(a_port_oe, {8{expOeA}}, "a_port_oe");
    check(b_port_oe, {8{expOeB}}, "b_port_oe");
    check(8'(driveMode), 8'(expMode), "driveMode");
    if (b_port_oe[0] === 1'b1) check(b_port_out, expBo, "b_port_out");
    if (a_port_oe[0] === 1'b1) check(a_port_out, expAo, "a_port_out");
  end
  initial begin
    repeat (8) @(posedge clk);
    rst <= 0;
    repeat (3) @(posedge clk);
    for (i = 0; i < 400; i++) begin
      r = $random(seed);
      {sa, sb, ea, en, ca, cb} = r[5:0];
      // a live select with both drivers on would close a loop through the buses
      if (ea && !en) {sa, sb} = 2'b11;
      cb = cb & !(ca & (sa | sb));
      @(posedge clk);
      {a_to_b_source_sel, b_to_a_source_sel} <= {sa, sb};
      {a_to_b_drive_en, b_to_a_drive_en_n, a_capture_clk, b_capture_clk} <= {ea, en, ca, cb};
      {aDrive, bDrive} <= r[23:8];
    end
    @(posedge clk);
    {a_capture_clk, b_capture_clk, a_to_b_drive_en, b_to_a_drive_en_n} <= 4'h1;
    capReady <= 0;
    repeat (10) @(posedge clk);
    @(negedge clk);
    pops = 0;
    drops = 0;
    for (i = 0; i < 25; i++) begin
      @(posedge clk);
      a_capture_clk <= i[0] & (i < 24);
      aDrive <= 8'($random(seed));
    end
    repeat (5) @(posedge clk);
    capReady <= 1;
    repeat (20) @(posedge clk);
    @(negedge clk);
    check(8'(pops + drops), 8'h0c, "captures");
    check(8'(pops), 8'h09, "held words");
    close_out();
  end
endmodule
